// >>> dv/awt_bank_checker.sv
// Port-level assertions for the window trigger bank
module awt_bank_checker (
  // Clock and reset
  input wire logic                           clk_i,
  input wire logic                           rstn_i,
  // Command side
  input wire awt_pkg::awt_cmd_t              cmd_i,
  input wire logic [awt_pkg::SLOT_W-1:0]     comparator_slot_i,
  input wire logic                           release_linked_i,
  input wire logic                           done_o,
  input wire logic                           error_o,
  // Status and comparator outputs
  input wire logic [awt_pkg::NUM_SLOTS-1:0]  slot_busy_o,
  input wire logic [awt_pkg::NUM_SLOTS-1:0]  channel_release_o,
  input wire logic [awt_pkg::NUM_SLOTS-1:0]  hysteresis_level_o,
  input wire logic [awt_pkg::NUM_SLOTS-1:0]  inside_band_o,
  input wire logic [awt_pkg::NUM_SLOTS-1:0]  pulse_o
);
  import awt_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  done_follows_a: assert property (cmd_i != AWT_CMD_NONE |=> done_o)
    else $error("done missing after command");
  done_cause_a: assert property (done_o |-> $past(cmd_i) != AWT_CMD_NONE)
    else $error("done without command");
  error_with_done_a: assert property (error_o |-> done_o)
    else $error("error outside answer");
  bad_slot_a: assert property (cmd_i == AWT_CMD_RELEASE && comparator_slot_i[3] |=> error_o)
    else $error("bad slot accepted");
  reserve_grows_a: assert property (cmd_i == AWT_CMD_RESERVE && slot_busy_o != 8'hFF |=>
    !error_o && $countones(slot_busy_o) == $countones($past(slot_busy_o)) + 1)
    else $error("reserve did not take one slot");
  reserve_full_a: assert property (cmd_i == AWT_CMD_RESERVE && &slot_busy_o |=>
    error_o && $stable(slot_busy_o))
    else $error("reserve on full bank not refused");
  pulse_edge_a: assert property (pulse_o == (hysteresis_level_o ^ $past(hysteresis_level_o)))
    else $error("pulse not tied to level change");
  rise_outside_a: assert property ($rose(hysteresis_level_o[0]) |-> !$past(inside_band_o[0]))
    else $error("level rose inside band");
  idle_quiet_a: assert property (!slot_busy_o[0] [*3] |-> !inside_band_o[0])
    else $error("free slot reports band");
  linked_free_a: assert property (channel_release_o != 8'h00 |->
    $past(cmd_i) == AWT_CMD_RELEASE && $past(release_linked_i))
    else $error("channel freed without linked release");
endmodule // awt_bank_checker

bind awt_bank awt_bank_checker awt_bank_checker_i (.clk_i, .rstn_i, .cmd_i, .comparator_slot_i,
  .release_linked_i, .done_o, .error_o, .slot_busy_o, .channel_release_o, .hysteresis_level_o,
  .inside_band_o, .pulse_o);

// >>> dv/awt_bank_tb.sv
// Self-checking bench for the window trigger bank
module awt_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import awt_pkg::*;
  logic clk_i, rstn_i, averaged_i, filter_i, release_linked_i, done_o, error_o;
  awt_sample_t tgt [NUM_SRC];
  awt_sample_t raw [NUM_SRC];
  awt_sample_t avg [NUM_SRC];
  awt_cmd_t cmd_i = AWT_CMD_NONE;
  logic [SLOT_W-1:0] comparator_slot_i = '0, comparator_handle_o;
  logic [SRC_W-1:0] source_i = '0;
  awt_sample_t high_threshold_i = 16'h0064, low_threshold_i = 16'hFF9C;
  logic [NUM_SLOTS-1:0] slot_busy_o, channel_release_o, hysteresis_level_o, inside_band_o, pulse_o;
  logic [NUM_SRC-1:0] channel_claimed_o;
  int error_cnt = 0, compares = 0, cyc = 0, npls = 0, p0;
  awt_chan_src awt_chan_src_i (.clk_i, .rstn_i, .tgt_i(tgt), .raw_o(raw), .avg_o(avg));
  awt_bank awt_bank_i (.clk_i, .rstn_i, .raw_sample_i(raw), .avg_sample_i(avg), .cmd_i,
    .comparator_slot_i, .source_i, .averaged_i, .filter_i, .release_linked_i, .high_threshold_i,
    .low_threshold_i, .done_o, .error_o, .comparator_handle_o, .slot_busy_o, .channel_claimed_o,
    .channel_release_o, .hysteresis_level_o, .inside_band_o, .pulse_o);
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(logic ok, string m);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One command, answer checked in the single cycle that done stands
  task automatic op(awt_cmd_t c, logic [3:0] s, so, logic a, f, l, e);
    @(posedge clk_i);
    cmd_i <= c;
    comparator_slot_i <= s;
    source_i <= so;
    {averaged_i, filter_i, release_linked_i} <= {a, f, l};
    @(posedge clk_i);
    cmd_i <= AWT_CMD_NONE;
    #1 chk(done_o === 1'b1 && error_o === e, "command answer");
  endtask
  task automatic put(int s, awt_sample_t v, int n);
    @(posedge clk_i);
    tgt[s] <= v;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Hang guard well above the roughly one hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    npls <= npls + int'(pulse_o[0]);
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 0;
    {averaged_i, filter_i, release_linked_i} = 3'h0;
    tgt = '{default: '0};
    repeat (10) @(posedge clk_i);
    #1 chk(slot_busy_o === 8'h00 && hysteresis_level_o === 8'h00 && pulse_o === 8'h00, "reset");
    @(posedge clk_i) rstn_i <= 1;
    for (int i = 0; i < 8; i++) begin
      op(AWT_CMD_RESERVE, 0, 0, 0, 0, 0, 0);
      chk(comparator_handle_o === i[3:0] && slot_busy_o[i] === 1'b1, "reserve slot");
    end
    op(AWT_CMD_RESERVE, 0, 0, 0, 0, 0, 1);
    op(AWT_CMD_RELEASE, 9, 0, 0, 0, 0, 1);
    op(AWT_CMD_CONFIG, 8, 0, 0, 0, 0, 1);
    op(AWT_CMD_RELEASE, 3, 0, 0, 0, 0, 0);
    chk(channel_release_o === 8'h00 && slot_busy_o[3] === 1'b0, "plain release");
    op(AWT_CMD_RELEASE, 3, 0, 0, 0, 0, 1);
    op(AWT_CMD_RESERVE, 0, 0, 0, 0, 0, 0);
    chk(comparator_handle_o === 4'h3, "lowest free slot");
    op(AWT_CMD_CONFIG, 0, 5, 0, 0, 0, 0);
    op(AWT_CMD_CONFIG, 1, 2, 1, 0, 0, 0);
    op(AWT_CMD_CONFIG, 2, 2, 0, 0, 0, 0);
    op(AWT_CMD_CONFIG, 4, 3, 0, 1, 0, 0);
    put(5, 16'h0000, 5);
    chk(inside_band_o[0] === 1'b1 && hysteresis_level_o[0] === 1'b0, "mid band");
    p0 = npls;
    put(5, 16'h00C8, 5);
    chk(inside_band_o[0] === 1'b0 && hysteresis_level_o[0] === 1'b1, "above band");
    put(5, 16'h0064, 5);
    chk(inside_band_o[0] === 1'b1 && hysteresis_level_o[0] === 1'b1, "hold at edge");
    put(5, 16'hFF38, 5);
    chk(inside_band_o[0] === 1'b0 && hysteresis_level_o[0] === 1'b0, "below band");
    chk(npls - p0 == 2, "one pulse per change");
    @(posedge clk_i) {tgt[2], tgt[3]} <= {16'h0096, 16'h0096};
    put(2, 16'h0000, 1);
    put(3, 16'h0000, 6);
    chk(hysteresis_level_o[2:1] === 2'h2, "raw versus averaged");
    chk(hysteresis_level_o[4] === 1'b0, "spike rejected");
    put(3, 16'h0096, 10);
    chk(hysteresis_level_o[4] === 1'b1, "steady change accepted");
    op(AWT_CMD_RELEASE, 0, 0, 0, 0, 1, 0);
    chk(channel_release_o === 8'h01 && channel_claimed_o[5] === 1'b0, "linked free");
    end_sim();
  end
endmodule // awt_bank_tb

// >>> dv/awt_chan_src.sv
// Analog channel model: prompt raw samples and a slow running average
module awt_chan_src (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rstn_i,
  // Wanted levels and produced samples
  input  wire awt_pkg::awt_sample_t tgt_i [awt_pkg::NUM_SRC],
  output awt_pkg::awt_sample_t      raw_o [awt_pkg::NUM_SRC],
  output awt_pkg::awt_sample_t      avg_o [awt_pkg::NUM_SRC]
);
  timeunit 1ns;
  timeprecision 1ps;
  import awt_pkg::*;
  // Average halves the step each clock, so a one-cycle spike never reaches full size
  always_ff @(posedge clk_i or negedge rstn_i) begin
    for (int i = 0; i < NUM_SRC; i++) begin
      raw_o[i] <= rstn_i ? tgt_i[i] : '0;
      avg_o[i] <= rstn_i ? (avg_o[i] + raw_o[i]) >>> 1 : '0;
    end
  end
endmodule // awt_chan_src

// >>> include/awt_cfg_if.sv
// Interface carrying one comparator's configuration and sample
interface awt_cfg_if;
  import awt_pkg::*;
  logic        en;
  logic        filt;
  awt_sample_t sample;
  awt_sample_t high_threshold;
  awt_sample_t low_threshold;
  modport ctl (output en, output filt, output sample, output high_threshold,
               output low_threshold);
  modport cmp (input en, input filt, input sample, input high_threshold,
               input low_threshold);
endinterface

// >>> include/awt_pkg.sv
// Constants and types shared by the analog window trigger bank
//
// What this block does
// - Eight comparator slots numbered 0 to 7 exist, and a command naming a bad slot is refused with an error flag.
// - Every comparator produces a hysteresis level, an inside-band flag and a pulse.
// - The inside-band flag is high exactly while a busy slot's sample lies between the low and high thresholds, registered one clock later.
// - The hysteresis level goes high when the sample is above the high threshold.
// - The hysteresis level goes low when the sample is below the low threshold.
// - Between the thresholds the hysteresis level keeps its last value.
// - Each comparator picks its source from any module and channel through a programmable selector.
// - All comparator outputs leave the block as vectors that counter and encoder logic can select.
// - Slots are reserved before use and released after, and the block tracks which slots are busy.
// - A release with the linked-input option frees the analog channel that the comparator used.
// - A per-comparator option chooses the averaged sample instead of the raw sample.
// - With the rejection filter on, a level change is accepted only after it persists for several samples.
package awt_pkg;
  localparam int unsigned NUM_SLOTS    = 8;
  localparam int unsigned SLOT_W       = 4;
  localparam int unsigned NUM_MODULES  = 2;
  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned NUM_SRC      = NUM_MODULES * NUM_CHANNELS;
  localparam int unsigned SRC_W        = 4;
  localparam int unsigned SAMPLE_W     = 16;
  localparam int unsigned FILT_W       = 2;
  localparam logic [FILT_W-1:0] FILT_HOLD = 2'h3;

  typedef enum logic [1:0] {AWT_CMD_NONE, AWT_CMD_RESERVE, AWT_CMD_RELEASE, AWT_CMD_CONFIG}
    awt_cmd_t;
  typedef logic signed [SAMPLE_W-1:0] awt_sample_t;
endpackage

// >>> verilog/awt_bank.sv
// Bank of eight window comparators with slot allocation
module awt_bank (
  // Clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   rstn_i,
  // Samples, raw and averaged, one per module channel
  input  wire awt_pkg::awt_sample_t                   raw_sample_i [awt_pkg::NUM_SRC],
  input  wire awt_pkg::awt_sample_t                   avg_sample_i [awt_pkg::NUM_SRC],
  // Command port
  input  wire awt_pkg::awt_cmd_t                      cmd_i,
  input  wire logic [awt_pkg::SLOT_W-1:0]             comparator_slot_i,
  input  wire logic [awt_pkg::SRC_W-1:0]              source_i,
  input  wire logic                                   averaged_i,
  input  wire logic                                   filter_i,
  input  wire logic                                   release_linked_i,
  input  wire awt_pkg::awt_sample_t                   high_threshold_i,
  input  wire awt_pkg::awt_sample_t                   low_threshold_i,
  // Command answer
  output logic                                        done_o,
  output logic                                        error_o,
  output logic [awt_pkg::SLOT_W-1:0]                  comparator_handle_o,
  // Status
  output logic [awt_pkg::NUM_SLOTS-1:0]               slot_busy_o,
  output logic [awt_pkg::NUM_SRC-1:0]                 channel_claimed_o,
  output logic [awt_pkg::NUM_SLOTS-1:0]               channel_release_o,
  // Comparator outputs towards counters and encoders
  output logic [awt_pkg::NUM_SLOTS-1:0]               hysteresis_level_o,
  output logic [awt_pkg::NUM_SLOTS-1:0]               inside_band_o,
  output logic [awt_pkg::NUM_SLOTS-1:0]               pulse_o
);
  import awt_pkg::*;

  logic [SRC_W-1:0]    src_reg   [NUM_SLOTS];
  logic                avg_reg   [NUM_SLOTS];
  logic                filt_reg  [NUM_SLOTS];
  awt_sample_t         high_reg  [NUM_SLOTS];
  awt_sample_t         low_reg   [NUM_SLOTS];
  logic                slot_ok;
  logic [SLOT_W-2:0]   idx;
  logic [SLOT_W-1:0]   free_slot;
  logic                free_found;
  logic                src_ok;
  logic                reserve_ok;
  logic                release_ok;
  logic                config_ok;

  assign slot_ok = comparator_slot_i < SLOT_W'(NUM_SLOTS);
  assign idx     = comparator_slot_i[SLOT_W-2:0];
  // Compared at full width: the source count does not fit the source field itself
  assign src_ok  = int'(source_i) < int'(NUM_SRC);

  // Lowest free slot wins a reservation
  always_comb begin
    free_slot  = '0;
    free_found = 1'b0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (!slot_busy_o[i]) begin
        free_slot  = SLOT_W'(i);
        free_found = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode; one command per clock, answered the next clock
  always_comb begin
    reserve_ok = cmd_i == AWT_CMD_RESERVE && free_found;
    release_ok = cmd_i == AWT_CMD_RELEASE && slot_ok && slot_busy_o[idx];
    config_ok  = cmd_i == AWT_CMD_CONFIG && slot_ok && slot_busy_o[idx] && src_ok;
  end

  // A refused command changes nothing but the answer strobes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o  <= 1'b0;
      error_o <= 1'b0;
    end else begin
      done_o  <= cmd_i != AWT_CMD_NONE;
      error_o <= cmd_i != AWT_CMD_NONE && !reserve_ok && !release_ok && !config_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_busy_o <= '0;
    end else if (reserve_ok) begin
      slot_busy_o[free_slot[SLOT_W-2:0]] <= 1'b1;
    end else if (release_ok) begin
      slot_busy_o[idx] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comparator_handle_o <= '0;
    end else if (reserve_ok) begin
      comparator_handle_o <= free_slot;
    end else if (release_ok || config_ok) begin
      comparator_handle_o <= comparator_slot_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      channel_release_o <= '0;
    end else begin
      channel_release_o <= '0;
      if (release_ok) begin
        channel_release_o[idx] <= release_linked_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        src_reg[i]  <= '0;
        avg_reg[i]  <= 1'b0;
        filt_reg[i] <= 1'b0;
        high_reg[i] <= '0;
        low_reg[i]  <= '0;
      end
    end else if (config_ok) begin
      src_reg[idx]  <= source_i;
      avg_reg[idx]  <= averaged_i;
      filt_reg[idx] <= filter_i;
      high_reg[idx] <= high_threshold_i;
      low_reg[idx]  <= low_threshold_i;
    end
  end

  // A channel stays claimed while any busy slot points at it
  always_comb begin
    channel_claimed_o = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (slot_busy_o[i]) begin
        channel_claimed_o[src_reg[i]] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_cmp
    awt_cfg_if cfg_if ();
    assign cfg_if.en             = slot_busy_o[g];
    assign cfg_if.filt           = filt_reg[g];
    assign cfg_if.sample         = avg_reg[g] ? avg_sample_i[src_reg[g]]
                                              : raw_sample_i[src_reg[g]];
    assign cfg_if.high_threshold = high_reg[g];
    assign cfg_if.low_threshold  = low_reg[g];
    awt_comparator u_cmp (
      .clk_i              (clk_i),
      .rstn_i             (rstn_i),
      .cfg                (cfg_if.cmp),
      .hysteresis_level_o (hysteresis_level_o[g]),
      .inside_band_o      (inside_band_o[g]),
      .pulse_o            (pulse_o[g])
    );
  end
endmodule // awt_bank

// >>> verilog/awt_comparator.sv
// One window comparator with hysteresis, pulse and rejection filter
module awt_comparator (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Configuration and sample
  awt_cfg_if.cmp    cfg,
  // Outputs
  output logic      hysteresis_level_o,
  output logic      inside_band_o,
  output logic      pulse_o
);
  import awt_pkg::*;

  logic                above;
  logic                below;
  logic                raw_next;
  logic                raw_reg;
  logic [FILT_W-1:0]   cnt_reg;
  logic                confirm;

  assign above = cfg.sample > cfg.high_threshold;
  assign below = cfg.sample < cfg.low_threshold;
  // Sample still beyond the threshold that the pending change came from; a freed slot always confirms
  assign confirm = !cfg.en || (raw_reg ? above : below);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    raw_next = raw_reg;
    if (above) begin
      raw_next = 1'b1;
    end else if (below) begin
      raw_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_reg <= 1'b0;
    end else if (!cfg.en) begin
      raw_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inside_band_o <= 1'b0;
    end else begin
      inside_band_o <= cfg.en && !above && !below;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filter counts agreeing cycles so a brief crossing does not flip the level;
  // the held raw level alone would let a spike through once the count runs out, so the live sample must agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else if (raw_reg == hysteresis_level_o || !confirm) begin
      cnt_reg <= '0;
    end else if (cnt_reg != FILT_HOLD) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hysteresis_level_o <= 1'b0;
      pulse_o            <= 1'b0;
    end else if (raw_reg != hysteresis_level_o && (!cfg.filt || cnt_reg == FILT_HOLD)) begin
      hysteresis_level_o <= raw_reg;
      pulse_o            <= 1'b1;
    end else begin
      pulse_o            <= 1'b0;
    end
  end
endmodule // awt_comparator
